// >>> gtc_pkg.sv
package gtc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and derived rates
  localparam int MCLK_HZ  = 20_000_000;
  localparam int INSN_HZ  = MCLK_HZ / 4;
  localparam int INSN_DIV = MCLK_HZ / INSN_HZ;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the APB
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_GATE   = 8'h04;
  localparam logic [7:0] OFS_CNT_LO = 8'h08;
  localparam logic [7:0] OFS_CNT_HI = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int OVF_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counter maximum
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  GATE_RST  = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Count clock sources
  typedef enum logic [1:0] {
    SRC_INSN = 2'h0,
    SRC_SYS  = 2'h1,
    SRC_EXT  = 2'h2,
    SRC_CAP  = 2'h3
  } gtc_src_t;

  // Timer control register, bit 7 down to bit 0
  typedef struct packed {
    gtc_src_t   clock_source_field;
    logic [1:0] prescale_field;
    logic       crystal_osc_enable;
    logic       sync_disable_bit;
    logic       rsvd;
    logic       timer_run_bit;
  } gtc_ctrl_t;

  // Gate control register, bit 7 down to bit 0
  typedef struct packed {
    logic       gate_enable_bit;
    logic       gate_polarity_bit;
    logic [5:0] rsvd;
  } gtc_gate_t;

endpackage

// >>> gtc_edge.sv
`timescale 1ns/100ps

module gtc_edge
  import gtc_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // Signal in
  input  wire logic sig,
  input  wire logic bypass,
  // Edges out
  output logic      rise,
  output logic      fall
);

  logic sync1_q;
  logic sync2_q;
  logic direct_q;
  logic prev_q;
  logic sel;

  // Two stages on the synchronised path, one on the bypass path
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sync1_q  <= 1'b0;
      sync2_q  <= 1'b0;
      direct_q <= 1'b0;
    end else begin
      sync1_q  <= sig;
      sync2_q  <= sync1_q;
      direct_q <= sig;
    end
  end

  // Switching paths shifts edge timing: one edge may be lost or doubled
  assign sel = bypass ? direct_q : sync2_q;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sel;
    end
  end

  assign rise = sel & ~prev_q;
  assign fall = ~sel & prev_q;

endmodule

// >>> gtc_timer.sv
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps

// How it works
// - Run bit and gate enable control counting
// - Sixteen-bit counter, byte writes replace live bytes
// - Source field and oscillator enable pick clock
// - System clock source adds four per instruction
// - External sources count on rising edges
// - Falling edge must precede first counted rise
// - Prescaler divides by one, two, four, eight
// - Prescaler hidden, cleared by count byte writes
// - Crystal oscillator on by enable, also sleeping
// - Sync disable passes external clock unsynchronised
// - Async external mode counts and wakes in sleep
// - Sync mode switch may gain or lose one
// - Rollover to zero sets sticky overflow flag
// - Gated mode counts only while gate active
module gtc_timer
  import gtc_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Count and gate inputs
  input  wire logic        external_count_pin,
  input  wire logic        cap_osc_clk,
  input  wire logic        gate_pin,
  // Crystal oscillator
  input  wire logic        crystal_in_pin,
  output logic             crystal_out_pin,
  output logic             crystal_amp_en,
  // Power state and events
  input  wire logic        sleep_in,
  output logic             overflow_flag,
  output logic             wake_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  gtc_ctrl_t   ctrl_q;
  gtc_gate_t   gate_q;
  logic [15:0] count_q;
  logic [2:0]  psc_q;
  logic [1:0]  div_q;
  logic        armed_q;
  logic        ovf_q;
  logic        wake_q;
  logic        xout_q;
  logic [31:0] prdata_q;
  logic        setup;
  logic        access;
  logic        hit;
  logic        wr_ctrl;
  logic        wr_gate;
  logic        wr_lo;
  logic        wr_hi;
  logic        wr_stat;
  logic        cnt_wr;
  logic        ext_sig;
  logic        ext_rise;
  logic        ext_fall;
  logic        ext_src;
  logic        src_tick;
  logic        gate_ok;
  logic        awake_ok;
  logic        cnt_en;
  logic        tick_in;
  logic [2:0]  psc_mask;
  logic        psc_done;
  logic        inc;
  logic        roll;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign setup  = psel & ~penable;
  assign access = psel & penable;

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr == OFS_CTRL) begin
      rd_mux[7:0] = ctrl_q;
    end else if (paddr == OFS_GATE) begin
      rd_mux[7:0] = gate_q;
    end else if (paddr == OFS_CNT_LO) begin
      rd_mux[7:0] = count_q[7:0];
    end else if (paddr == OFS_CNT_HI) begin
      rd_mux[7:0] = count_q[15:8];
    end else if (paddr == OFS_STATUS) begin
      rd_mux[OVF_BIT] = ovf_q;
    end else begin
      hit = 1'b0;
    end
  end

  // Zero wait states; read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata  = prdata_q;

  assign wr_ctrl = access & pwrite & (paddr == OFS_CTRL);
  assign wr_gate = access & pwrite & (paddr == OFS_GATE);
  assign wr_lo   = access & pwrite & (paddr == OFS_CNT_LO);
  assign wr_hi   = access & pwrite & (paddr == OFS_CNT_HI);
  assign wr_stat = access & pwrite & (paddr == OFS_STATUS);
  assign cnt_wr  = wr_lo | wr_hi;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_q <= gtc_ctrl_t'(CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_q      <= gtc_ctrl_t'(pwdata[7:0]);
      ctrl_q.rsvd <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      gate_q <= gtc_gate_t'(GATE_RST);
    end else if (wr_gate) begin
      gate_q      <= gtc_gate_t'(pwdata[7:0]);
      gate_q.rsvd <= 6'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crystal oscillator: held by its enable bit, unaffected by sleep
  assign crystal_amp_en  = ctrl_q.crystal_osc_enable;
  assign crystal_out_pin = xout_q;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      xout_q <= 1'b0;
    end else begin
      xout_q <= ctrl_q.crystal_osc_enable & ~crystal_in_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock source selection and edge detection
  assign ext_src = (ctrl_q.clock_source_field == SRC_EXT) ||
                   (ctrl_q.clock_source_field == SRC_CAP);

  always_comb begin
    if (ctrl_q.clock_source_field == SRC_CAP) begin
      ext_sig = cap_osc_clk;
    end else if (ctrl_q.crystal_osc_enable) begin
      ext_sig = crystal_in_pin;
    end else begin
      ext_sig = external_count_pin;
    end
  end

  gtc_edge u_edge (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .sig    (ext_sig),
    .bypass (ctrl_q.sync_disable_bit),
    .rise   (ext_rise),
    .fall   (ext_fall)
  );

  // Instruction clock is a quarter of the system clock
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  // A high input at enable must drop before its rise may count
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
    end else if (!ctrl_q.timer_run_bit || cnt_wr) begin
      armed_q <= 1'b0;
    end else if (ext_fall) begin
      armed_q <= 1'b1;
    end
  end

  always_comb begin
    case (ctrl_q.clock_source_field)
      SRC_SYS:  src_tick = 1'b1;
      SRC_INSN: src_tick = (div_q == 2'(INSN_DIV - 1));
      default:  src_tick = ext_rise & armed_q;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count enable
  // Gate level is matched to the polarity bit; no resync here, so the
  // gate pin must already be clean with respect to mclk
  assign gate_ok  = ~gate_q.gate_enable_bit |
                    (gate_pin == gate_q.gate_polarity_bit);
  assign awake_ok = ~sleep_in |
                    (ctrl_q.sync_disable_bit & ext_src);
  assign cnt_en   = ctrl_q.timer_run_bit & gate_ok & awake_ok;
  assign tick_in  = cnt_en & src_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler
  always_comb begin
    case (ctrl_q.prescale_field)
      2'h0:    psc_mask = 3'h0;
      2'h1:    psc_mask = 3'h1;
      2'h2:    psc_mask = 3'h3;
      default: psc_mask = 3'h7;
    endcase
  end

  assign psc_done = ((psc_q & psc_mask) == psc_mask);
  assign inc      = tick_in & psc_done;
  assign roll     = inc & (count_q == COUNT_MAX);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      psc_q <= 3'h0;
    end else if (cnt_wr) begin
      psc_q <= 3'h0;
    end else if (tick_in) begin
      psc_q <= psc_done ? 3'h0 : psc_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter; a byte write wins over an increment in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      count_q <= COUNT_RST;
    end else if (wr_lo) begin
      count_q[7:0] <= pwdata[7:0];
    end else if (wr_hi) begin
      count_q[15:8] <= pwdata[7:0];
    end else if (inc) begin
      count_q <= count_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow flag and wake strobe; a rollover beats a clear
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ovf_q <= 1'b0;
    end else if (roll) begin
      ovf_q <= 1'b1;
    end else if (wr_stat && pwdata[OVF_BIT]) begin
      ovf_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= roll & sleep_in;
    end
  end

  assign overflow_flag = ovf_q;
  assign wake_pulse    = wake_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  run_off_hold_a: assert property (@(posedge mclk)
    disable iff (!rst_b)
    !ctrl_q.timer_run_bit && !cnt_wr |=> count_q == $past(count_q))
    else $error("count moved while stopped");

  low_write_a: assert property (@(posedge mclk)
    disable iff (!rst_b) wr_lo |=> count_q[7:0] == $past(pwdata[7:0]))
    else $error("low byte write not applied");

  sys_rate_a: assert property (@(posedge mclk)
    disable iff (!rst_b)
    ctrl_q.timer_run_bit && !gate_q.gate_enable_bit && !sleep_in &&
    ctrl_q.clock_source_field == SRC_SYS && ctrl_q.prescale_field == 2'h0
    && !cnt_wr |=> count_q == $past(count_q) + 16'h0001)
    else $error("system clock source did not count every cycle");

  insn_rate_a: assert property (@(posedge mclk)
    disable iff (!rst_b)
    (ctrl_q.timer_run_bit && !gate_q.gate_enable_bit && !sleep_in &&
    ctrl_q.clock_source_field == SRC_INSN &&
    ctrl_q.prescale_field == 2'h0 && !cnt_wr)[*4]
    |=> count_q == $past(count_q, 4) + 16'h0001)
    else $error("instruction clock source rate wrong");

  arm_needed_a: assert property (@(posedge mclk)
    disable iff (!rst_b)
    ext_src && !armed_q && !cnt_wr |=> count_q == $past(count_q))
    else $error("count before falling edge seen");

  async_count_a: assert property (@(posedge mclk)
    disable iff (!rst_b)
    ctrl_q.timer_run_bit && !gate_q.gate_enable_bit && ext_src &&
    ctrl_q.sync_disable_bit && ctrl_q.prescale_field == 2'h0 &&
    armed_q && ext_rise && !cnt_wr
    |=> count_q == $past(count_q) + 16'h0001)
    else $error("asynchronous external rise not counted");

  prescale_a: assert property (@(posedge mclk)
    disable iff (!rst_b)
    ctrl_q.prescale_field == 2'h2 && psc_q[1:0] != 2'h3 && !cnt_wr
    |=> count_q == $past(count_q))
    else $error("divide by four counted early");

  psc_clear_a: assert property (@(posedge mclk)
    disable iff (!rst_b) cnt_wr |=> psc_q == 3'h0)
    else $error("prescaler not cleared by count write");

  ovf_set_a: assert property (@(posedge mclk)
    disable iff (!rst_b)
    inc && !cnt_wr && count_q == COUNT_MAX
    |=> ovf_q && count_q == COUNT_RST)
    else $error("rollover did not set overflow");

  ovf_sticky_a: assert property (@(posedge mclk)
    disable iff (!rst_b) ovf_q && !(wr_stat && pwdata[OVF_BIT]) |=> ovf_q)
    else $error("overflow flag dropped without a clear");

  gate_hold_a: assert property (@(posedge mclk)
    disable iff (!rst_b)
    gate_q.gate_enable_bit && gate_pin != gate_q.gate_polarity_bit &&
    !cnt_wr |=> count_q == $past(count_q))
    else $error("count moved with gate inactive");

  sleep_hold_a: assert property (@(posedge mclk)
    disable iff (!rst_b)
    sleep_in && !ctrl_q.sync_disable_bit && !cnt_wr
    |=> count_q == $past(count_q))
    else $error("synchronous mode counted in sleep");

  wake_sleep_a: assert property (@(posedge mclk)
    disable iff (!rst_b) roll && sleep_in |=> wake_pulse)
    else $error("rollover in sleep gave no wake pulse");

endmodule

// >>> gtc_src_model.sv
`timescale 1ns/100ps

module gtc_src_model (
  // Clock
  input  wire logic mclk,
  // Count sources
  output logic      ext_pin,
  output logic      xtal_pin,
  output logic      cap_clk
);
  logic       lvl;
  logic [2:0] msk;

  // Unselected sources and idle time stay low, so no stray edge
  assign {cap_clk, xtal_pin, ext_pin} = msk & {3{lvl}};

  initial begin
    lvl = 1'b0;
    msk = 3'h0;
  end

  // Burst of n pulses, hp mclk cycles per half period
  task automatic burst(input int n, input int hp, input int sel);
    msk <= 3'h1 << sel;
    repeat (n) begin
      repeat (hp) @(posedge mclk);
      lvl <= 1'b1;
      repeat (hp) @(posedge mclk);
      lvl <= 1'b0;
    end
    repeat (hp) @(posedge mclk);
  endtask
endmodule

// >>> tb_gtc_timer.sv
`timescale 1ns/100ps

module tb_gtc_timer
  import gtc_pkg::*;
;
  logic        mclk, rst_b, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, ext_pin, xtal, cap;
  logic        gate_pin, sleep_in, amp_en, ovf, wake, xout;
  int          n_fail, cmp_count, n_wake;
  logic [32:0] expq[$];

  gtc_timer i_gtc_timer (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_pin(ext_pin), .cap_osc_clk(cap), .gate_pin(gate_pin),
    .crystal_in_pin(xtal), .crystal_out_pin(xout), .crystal_amp_en(amp_en),
    .sleep_in(sleep_in), .overflow_flag(ovf), .wake_pulse(wake));

  gtc_src_model i_gtc_src_model (.mclk(mclk), .ext_pin(ext_pin),
    .xtal_pin(xtal), .cap_clk(cap));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_fail == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [32:0] e,
                     input logic [32:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int t;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) begin
      n_fail++;
      end_of_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following call never drives psel twice in one step
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Expected {pslverr, prdata} queued; the monitor judges it
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic err);
    expq.push_back({err, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  function automatic logic [31:0] cw(gtc_src_t s, logic [1:0] p,
                                     logic osc, logic sy, logic run);
    gtc_ctrl_t c;
    c = '{s, p, osc, sy, 1'b0, run};
    return {24'h0000_00, c};
  endfunction

  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expq.size() == 0)
        chk("read unexpected", 33'h0_0000_0000, {pslverr, prdata});
      else
        chk("read", expq.pop_front(), {pslverr, prdata});
    end
    if (wake === 1'b1)
      n_wake <= n_wake + 1;
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int          hp, w0;
    logic [31:0] r, c;
    logic [7:0]  ofs[5];
    n_fail = 0;
    cmp_count = 0;
    {rst_b, psel, penable, pwrite, gate_pin, sleep_in} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ofs = '{OFS_CTRL, OFS_GATE, OFS_CNT_LO, OFS_CNT_HI, OFS_STATUS};
    r = $urandom(32'h52b1);
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    foreach (ofs[k]) rd(ofs[k], 32'h0000_0000, 1'b0);
    rd(8'h14, 32'h0000_0000, 1'b1);
    wr(OFS_CTRL, 32'h0000_0002);
    rd(OFS_CTRL, 32'h0000_0000, 1'b0);
    // Random count bytes held while stopped
    r = $urandom;
    wr(OFS_CNT_LO, {24'h0000_00, r[7:0]});
    wr(OFS_CNT_HI, {24'h0000_00, r[15:8]});
    repeat (5) @(posedge mclk);
    rd(OFS_CNT_LO, {24'h0000_00, r[7:0]}, 1'b0);
    rd(OFS_CNT_HI, {24'h0000_00, r[15:8]}, 1'b0);
    // Only the system clock is fast enough to wrap in 40 cycles
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CNT_LO, 32'h0000_00F0);
      wr(OFS_CNT_HI, 32'h0000_00FF);
      c = cw(i ? SRC_INSN : SRC_SYS, 2'h0, 1'b0, 1'b0, 1'b0);
      wr(OFS_CTRL, c | 1);
      repeat (40) @(posedge mclk);
      wr(OFS_CTRL, c);
      rd(OFS_CNT_HI, i ? 32'h0000_00FF : 32'h0, 1'b0);
      rd(OFS_STATUS, {31'h0, i == 0}, 1'b0);
      wr(OFS_STATUS, 32'h0000_0001);
      rd(OFS_STATUS, 32'h0000_0000, 1'b0);
    end
    // Each external source and each prescale setting; the pin source runs twice
    for (int i = 0; i < 4; i++) begin
      c = cw(i == 3 ? SRC_CAP : SRC_EXT, 2'(i), i == 2, i == 1, 1'b0);
      wr(OFS_CTRL, c);
      repeat (20) @(posedge mclk); // Oscillator settles first
      chk("amp enable", {32'h0, i == 2}, {32'h0, amp_en});
      chk("crystal out", {32'h0, i == 2}, {32'h0, xout});
      wr(OFS_CTRL, c | 1);
      wr(OFS_CNT_LO, 32'h0000_0000);
      wr(OFS_CNT_HI, 32'h0000_0000);
      hp = 3 + ($urandom % 4);
      i_gtc_src_model.burst(17, hp, i < 2 ? 0 : i - 1);
      wr(OFS_CTRL, c);
      rd(OFS_CNT_LO, 16 >> i, 1'b0);
      rd(OFS_CNT_HI, 32'h0000_0000, 1'b0);
    end
    // Gated counting, full-resolution gate driven by the bench
    c = cw(SRC_EXT, 2'h0, 1'b0, 1'b0, 1'b1);
    wr(OFS_CTRL, c);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_GATE, {24'h0000_00, 1'b1, i[1], 6'h00});
      gate_pin <= i[0];
      wr(OFS_CNT_LO, 32'h0000_0000);
      i_gtc_src_model.burst(5, 4, 0);
      rd(OFS_CNT_LO, (i[1] == i[0]) ? 4 : 0, 1'b0);
    end
    wr(OFS_GATE, 32'h0000_0000);
    // Sleep: async external wraps and wakes, synchronous mode freezes
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL, cw(SRC_EXT, 2'h0, 1'b0, i == 0, 1'b1));
      wr(OFS_CNT_LO, 32'h0000_00FF);
      wr(OFS_CNT_HI, 32'h0000_00FF);
      w0 = n_wake;
      sleep_in <= 1'b1;
      i_gtc_src_model.burst(3, 4, 0);
      sleep_in <= 1'b0;
      @(posedge mclk);
      chk("wake pulses", i ? 0 : 1, n_wake - w0);
      chk("overflow pin", {32'h0, i == 0}, {32'h0, ovf});
      rd(OFS_CNT_LO, i ? 32'hFF : 32'h01, 1'b0);
      rd(OFS_STATUS, i ? 32'h0 : 32'h1, 1'b0);
      wr(OFS_STATUS, 32'h0000_0001);
    end
    @(posedge mclk);
    chk("queue empty", 33'h0, expq.size());
    end_of_test();
  end
endmodule
